// ### design/ram_section_power_ctrl.v
// apb register bank steering ram blocks 1 to 3 section power and retention
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "ram_power_defs.vh"

module ram_section_power_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        system_off,
  output wire [5:0]  sec_power,
  output wire [5:0]  sec_retain
);

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [7:0] block_sel;
  wire [3:0] alias_sel;
  wire       access;
  wire       hit_alias;
  wire [2:0] blk_hit;
  wire [2:0] wr_ctrl;
  wire [2:0] wr_set;
  wire [2:0] wr_clear;
  wire [31:0] ctrl1;
  wire [31:0] ctrl2;
  wire [31:0] ctrl3;
  reg  [31:0] next_prdata;

  assign block_sel = paddr[`BLOCK_ADDR_MSB:`BLOCK_ADDR_LSB];
  assign alias_sel = paddr[`ALIAS_ADDR_MSB:`ALIAS_ADDR_LSB];

  // zero wait states; unmapped addresses are not an error, they read zero
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign access  = psel & penable;

  assign hit_alias = (alias_sel == `ALIAS_CTRL) | (alias_sel == `ALIAS_SET) |
                     (alias_sel == `ALIAS_CLEAR);
  assign blk_hit   = {block_sel == `BLOCK3_SEL, block_sel == `BLOCK2_SEL,
                      block_sel == `BLOCK1_SEL} & {3{hit_alias}};

  // writes take effect only at the access phase edge
  assign wr_ctrl  = blk_hit & {3{access & pwrite & (alias_sel == `ALIAS_CTRL)}};
  assign wr_set   = blk_hit & {3{access & pwrite & (alias_sel == `ALIAS_SET)}};
  assign wr_clear = blk_hit & {3{access & pwrite & (alias_sel == `ALIAS_CLEAR)}};

  //////////////////////////////////////////////////////////////////////////////
  // per block registers

  section_ctrl_reg u_reg1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_ctrl  (wr_ctrl[0]),
    .wr_set   (wr_set[0]),
    .wr_clear (wr_clear[0]),
    .wdata    (pwdata),
    .ctrl     (ctrl1)
  );

  section_ctrl_reg u_reg2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_ctrl  (wr_ctrl[1]),
    .wr_set   (wr_set[1]),
    .wr_clear (wr_clear[1]),
    .wdata    (pwdata),
    .ctrl     (ctrl2)
  );

  section_ctrl_reg u_reg3 (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_ctrl  (wr_ctrl[2]),
    .wr_set   (wr_set[2]),
    .wr_clear (wr_clear[2]),
    .wdata    (pwdata),
    .ctrl     (ctrl3)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // all three aliases of a block return its ctrl word
  always @* begin
    next_prdata = `ZERO_WORD;
    case (blk_hit)
      3'h1:    next_prdata = ctrl1;
      3'h2:    next_prdata = ctrl2;
      3'h4:    next_prdata = ctrl3;
      default: next_prdata = `ZERO_WORD;
    endcase
  end

  // captured in setup so data is valid through the zero-wait access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ZERO_WORD;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // section switch drive

  section_switch u_sw1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .system_off (system_off),
    .ctrl       (ctrl1),
    .sec_power  (sec_power[1:0]),
    .sec_retain (sec_retain[1:0])
  );

  section_switch u_sw2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .system_off (system_off),
    .ctrl       (ctrl2),
    .sec_power  (sec_power[3:2]),
    .sec_retain (sec_retain[3:2])
  );

  section_switch u_sw3 (
    .pclk       (pclk),
    .presetn    (presetn),
    .system_off (system_off),
    .ctrl       (ctrl3),
    .sec_power  (sec_power[5:4]),
    .sec_retain (sec_retain[5:4])
  );

endmodule // ram_section_power_ctrl

// ### inc/ram_power_defs.vh
// constants for the ram section power register bank
`ifndef RAM_POWER_DEFS_VH
`define RAM_POWER_DEFS_VH

`define RAM1_SECTION_CTRL_ADDR   12'h910
`define RAM1_SECTION_SET_ADDR    12'h914
`define RAM1_SECTION_CLEAR_ADDR  12'h918
`define RAM2_SECTION_CTRL_ADDR   12'h920
`define RAM2_SECTION_SET_ADDR    12'h924
`define RAM2_SECTION_CLEAR_ADDR  12'h928
`define RAM3_SECTION_CTRL_ADDR   12'h930
`define RAM3_SECTION_SET_ADDR    12'h934
`define RAM3_SECTION_CLEAR_ADDR  12'h938
`define BLOCK_ADDR_MSB           11
`define BLOCK_ADDR_LSB           4
`define ALIAS_ADDR_MSB           3
`define ALIAS_ADDR_LSB           0
`define ALIAS_CTRL               4'h0
`define ALIAS_SET                4'h4
`define ALIAS_CLEAR              4'h8
`define BLOCK1_SEL               8'h91
`define BLOCK2_SEL               8'h92
`define BLOCK3_SEL               8'h93

`define SEC0_ON_BIT              0
`define SEC1_ON_BIT              1
`define SEC0_KEEP_BIT            16
`define SEC1_KEEP_BIT            17
`define SECTION_CTRL_RESET       32'h0000ffff
`define ZERO_WORD                32'h00000000
`define SWITCH_RESET             2'h3
`define SWITCH_ALL_OFF           2'h0

`endif

// ### design/section_ctrl_reg.v
// one block's control register with its set and clear aliases
`timescale 1ns/1ns
`include "ram_power_defs.vh"

module section_ctrl_reg (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        wr_ctrl,
  input  wire        wr_set,
  input  wire        wr_clear,
  input  wire [31:0] wdata,
  output reg  [31:0] ctrl
);

  reg [31:0] next_ctrl;

  // plain write replaces, set alias ors in, clear alias masks out; zeros leave bits alone
  always @* begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = wdata;
    end else if (wr_set) begin
      next_ctrl = ctrl | wdata;
    end else if (wr_clear) begin
      next_ctrl = ctrl & ~wdata;
    end
  end

  // all bits are stored so the reset pattern reads back whole
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SECTION_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

endmodule // section_ctrl_reg

// ### design/section_switch.v
// power and retention drive for the two sections of one block
`timescale 1ns/1ns
`include "ram_power_defs.vh"

module section_switch (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        system_off,
  input  wire [31:0] ctrl,
  output reg  [1:0]  sec_power,
  output reg  [1:0]  sec_retain
);

  wire [1:0] on_bits;
  wire [1:0] keep_bits;
  assign on_bits   = {ctrl[`SEC1_ON_BIT], ctrl[`SEC0_ON_BIT]};
  assign keep_bits = {ctrl[`SEC1_KEEP_BIT], ctrl[`SEC0_KEEP_BIT]};

  // registered so the switch drive never glitches on a bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_power  <= `SWITCH_RESET;
      sec_retain <= `SWITCH_RESET;
    end else begin
      sec_power  <= system_off ? `SWITCH_ALL_OFF : on_bits;
      sec_retain <= (system_off ? `SWITCH_ALL_OFF : on_bits) | keep_bits;
    end
  end

endmodule // section_switch

// ### test/ram_section_power_ctrl_checker.sv
// assertion checker for the ram section power register bank
`timescale 1ns/1ns
module ram_section_power_ctrl_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic        system_off,
  input logic [5:0]  sec_power,
  input logic [5:0]  sec_retain
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // taken write and read setup cycles
  wire wr = psel && penable && pwrite;
  wire rs = psel && !penable && !pwrite;
  AST_OFF: assert property ($past(system_off) |-> sec_power == 6'h00)
    else $error("section powered in system off");
  AST_RETAIN: assert property ((sec_power & ~sec_retain) == 6'h00)
    else $error("powered section not retained");
  AST_CTRL: assert property (wr && paddr == 12'h910 ##1 !system_off
    |=> sec_power[1:0] == $past(pwdata[1:0], 2)) else $error("power bits wrong");
  AST_KEEP: assert property (wr && paddr == 12'h910 ##1 !system_off |=>
    sec_retain[1:0] == ($past(pwdata[1:0], 2) | $past(pwdata[17:16], 2)))
    else $error("keep bits wrong");
  AST_SET: assert property (wr && paddr == 12'h924 && pwdata[0] ##1 !system_off
    |=> sec_power[2]) else $error("set alias failed");
  AST_CLR: assert property (wr && paddr == 12'h928 && pwdata[1] |=> ##1 !sec_power[3])
    else $error("clear alias failed");
  AST_READ: assert property (rs && paddr == 12'h918 && !system_off
    |=> prdata[1:0] == sec_power[1:0]) else $error("alias read differs");
  AST_HOLE: assert property (rs && paddr == 12'h91c |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_READY: assert property (psel && penable |-> pready && !pslverr)
    else $error("bad bus answer");
endmodule // ram_section_power_ctrl_checker

// ### test/ram_section_power_ctrl_test.sv
// self-checking bench for the ram section power register bank
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module ram_section_power_ctrl_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, system_off = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  wire         pready, pslverr;
  wire  [31:0] prdata;
  wire  [5:0]  sec_power, sec_retain;
  int          errors = 0, compares = 0, cyc = 0;
  ram_section_power_ctrl dut (.*);
  always #10 pclk = ~pclk;
  // hang guard, far beyond the hundred or so cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // one apb transfer; read data taken at the pready edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    `CHK(pslverr, 1'b0)
    psel <= 0; penable <= 0;
  endtask
  // outputs settle one edge after the register moves
  task automatic outs(input logic [5:0] p, input logic [5:0] r);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(sec_power, p)
    `CHK(sec_retain, r)
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // every register and alias of the three blocks from reset
  task automatic reset_values;
    for (int i = 0; i < 9; i++) begin
      xfer(0, 12'(12'h910 + i / 3 * 16 + i % 3 * 4), 0);
      `CHK(rd, 32'h0000ffff)
    end
    outs(6'h3f, 6'h3f);
  endtask
  // plain write on block 1, clear and set aliases on block 2
  task automatic alias_writes;
    xfer(1, 12'h910, 32'h00010000);
    outs(6'h3c, 6'h3d);
    xfer(0, 12'h918, 0);
    `CHK(rd, 32'h00010000)
    xfer(1, 12'h928, 32'h00000002);
    outs(6'h34, 6'h35);
    xfer(1, 12'h924, 32'h00020001);
    outs(6'h34, 6'h3d);
    xfer(0, 12'h924, 0);
    `CHK(rd, 32'h0002fffd)
  endtask
  // system off drops every section; leaving it restores the drive
  task automatic off_mode;
    @(posedge pclk);
    system_off <= 1;
    outs(6'h00, 6'h09);
    @(posedge pclk);
    system_off <= 0;
    outs(6'h34, 6'h3d);
  endtask
  // unmapped hole ignores writes and reads zero
  task automatic unmapped;
    xfer(1, 12'h91c, 32'hffffffff);
    xfer(0, 12'h91c, 0);
    `CHK(rd, 32'h00000000)
    xfer(0, 12'h910, 0);
    `CHK(rd, 32'h00010000)
  endtask
  // block 3 through its plain, set and clear registers
  task automatic block3;
    xfer(1, 12'h930, 32'h00000001);
    outs(6'h14, 6'h1d);
    xfer(1, 12'h934, 32'h00020002);
    outs(6'h34, 6'h3d);
    xfer(1, 12'h938, 32'h00000001);
    outs(6'h24, 6'h2d);
    xfer(0, 12'h938, 0);
    `CHK(rd, 32'h00020002)
  endtask
  // a second reset mid-run restores registers and drive
  task automatic mid_reset;
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h930, 0);
    `CHK(rd, 32'h0000ffff)
    outs(6'h3f, 6'h3f);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    reset_values();
    alias_writes();
    off_mode();
    unmapped();
    block3();
    mid_reset();
    report_and_stop();
  end
endmodule // ram_section_power_ctrl_test
bind ram_section_power_ctrl ram_section_power_ctrl_checker chk (.*);
